// File: hdl/cache_mode_control.sv
// Cache mode control: control flags, page attributes and snoop policy.
// Assumes synchronous inputs on clk; requests decided one cycle later.
module cache_mode_control #(
    parameter bit OLDER_FAMILY = 1'b0,
    parameter int ADDR_W       = 32
) (
    // Clock and reset
    input  wire logic                              clk,
    input  wire logic                              reset,
    // Control register writes
    input  wire logic                              ctrl_wr_en,
    input  wire logic [cache_mode_pkg::CTRL_W-1:0] ctrl_wr_data,
    input  wire logic                              pbr_wr_en,
    input  wire logic [cache_mode_pkg::CTRL_W-1:0] pbr_wr_data,
    input  wire logic                              fsr_wr_en,
    input  wire logic [cache_mode_pkg::CTRL_W-1:0] fsr_wr_data,
    // System state
    input  wire logic                              paging_en,
    input  wire logic                              region_regs_disabled,
    input  wire logic                              all_uncached,
    input  wire logic                              region_promote_ok,
    input  wire logic                              dual_processor,
    // External cache control pins
    input  wire logic                              cache_enable_in_n,
    input  wire logic                              writeback_select_in,
    // Access request
    input  cache_mode_pkg::access_req_t            access_req,
    // Snoops and invalidation
    input  wire logic                              snoop_valid,
    input  wire logic                              snoop_inval_req,
    input  wire logic [ADDR_W-1:0]                 snoop_addr,
    input  wire logic                              snoop_parity,
    input  wire logic                              invalidate_instr,
    input  wire logic                              writeback_invalidate_instr,
    // Register contents and fault
    output logic [cache_mode_pkg::CTRL_W-1:0]      ctrl_value_r,
    output logic [cache_mode_pkg::CTRL_W-1:0]      pbr_value_r,
    output logic [cache_mode_pkg::CTRL_W-1:0]      fsr_value_r,
    output logic                                   protection_fault_r,
    output logic [cache_mode_pkg::FAULT_CODE_W-1:0] fault_code_r,
    // Mode status
    output cache_mode_pkg::cache_mode_t            mode_r,
    output logic                                   strict_order_r,
    output logic                                   l3_enable_r,
    // Line handling
    output cache_mode_pkg::line_action_t           action_r,
    // Snoop answers
    output cache_mode_pkg::snoop_reply_t           snoop_reply_r,
    output logic                                   addr_parity_error_out_r,
    output logic                                   flush_lines_r,
    output logic                                   writeback_lines_r,
    // Page pins for an external cache
    output logic                                   page_uncached_pin_r,
    output logic                                   page_write_through_pin_r
);
    import cache_mode_pkg::*;

    cache_mode_t  mode;
    line_action_t action_nxt;
    snoop_reply_t snoop_nxt;
    logic         cd;
    logic         nw;
    logic         sel_uc;
    logic         sel_wt;
    logic         page_uc_eff;
    logic         page_wt_eff;
    logic         ext_uc;
    logic         ext_wt;
    logic         cacheable;
    logic         wt;
    logic         wr_hit;
    logic         l1_accept;
    logic         parity_err;

    assign cd = ctrl_value_r[CACHE_DISABLE_BIT];
    assign nw = ctrl_value_r[WRITE_POLICY_BIT];

    mode_decode #(
        .OLDER_FAMILY (OLDER_FAMILY)
    ) u_mode_decode (
        .ctrl_value (ctrl_value_r),
        .mode       (mode)
    );

    // First control register with reset state per family
    always_ff @(posedge clk) begin
        if (reset) begin
            ctrl_value_r <= OLDER_FAMILY ? CTRL_RESET_OLD
                                         : CTRL_RESET_NEW;
        end else if (ctrl_wr_en && !bad_setting(ctrl_wr_data)) begin
            ctrl_value_r <= ctrl_wr_data;
        end
    end

    // Rejected setting raises a fault pulse
    always_ff @(posedge clk) begin
        if (reset) begin
            protection_fault_r <= 1'b0;
            fault_code_r       <= FAULT_CODE_ZERO;
        end else begin
            protection_fault_r <= ctrl_wr_en
                                  && bad_setting(ctrl_wr_data);
            fault_code_r       <= FAULT_CODE_ZERO;
        end
    end

    // Page-base control register
    always_ff @(posedge clk) begin
        if (reset) begin
            pbr_value_r <= PBR_RESET;
        end else if (pbr_wr_en) begin
            pbr_value_r <= pbr_wr_data;
        end
    end

    // Feature switch register
    always_ff @(posedge clk) begin
        if (reset) begin
            fsr_value_r <= FSR_RESET;
        end else if (fsr_wr_en) begin
            fsr_value_r <= fsr_wr_data;
        end
    end

    // Mode status, ordering and third-level enable
    always_ff @(posedge clk) begin
        if (reset) begin
            mode_r         <= MODE_NORMAL;
            strict_order_r <= 1'b0;
            l3_enable_r    <= 1'b0;
        end else begin
            mode_r         <= mode;
            strict_order_r <= region_regs_disabled || all_uncached;
            l3_enable_r    <= !fsr_value_r[L3_DISABLE_BIT];
        end
    end

    // Directory accesses take page-base flags, others the entry flags
    assign sel_uc = access_req.dir_access ? pbr_value_r[PAGE_UC_BIT]
                                          : access_req.page_uncached_flag;
    assign sel_wt = access_req.dir_access ? pbr_value_r[PAGE_WT_BIT]
                                          : access_req.page_write_through_flag;
    assign page_uc_eff = paging_en && !cd && sel_uc;
    assign page_wt_eff = paging_en && !nw && sel_wt;

    // External pins apply only to the older family
    assign ext_uc = OLDER_FAMILY && cache_enable_in_n;
    assign ext_wt = OLDER_FAMILY && !writeback_select_in;

    assign cacheable = !page_uc_eff && !ext_uc;
    assign wt        = page_wt_eff || ext_wt;
    assign wr_hit    = access_req.is_write && access_req.hit;

    // Line handling per mode
    always_comb begin
        action_nxt               = '0;
        action_nxt.valid         = access_req.valid;
        action_nxt.cacheable     = cacheable;
        action_nxt.write_through = wt;
        action_nxt.update_line   = wr_hit;
        unique case (mode)
            MODE_NORMAL: begin
                action_nxt.allocate = cacheable && !access_req.hit;
                action_nxt.write_memory = access_req.is_write
                    && (!access_req.hit || access_req.line_shared
                        || wt || !cacheable);
                action_nxt.to_modified = wr_hit && !wt
                    && access_req.line_exclusive;
                if (wr_hit && access_req.line_shared && !wt) begin
                    if (OLDER_FAMILY) begin
                        action_nxt.to_exclusive = writeback_select_in;
                    end else begin
                        action_nxt.to_modified     = region_promote_ok;
                        action_nxt.read_invalidate = region_promote_ok;
                    end
                end
            end
            MODE_NO_FILL: begin
                action_nxt.allocate = 1'b0;
                action_nxt.write_memory = access_req.is_write
                    && (!access_req.hit || access_req.line_shared
                        || wt);
                action_nxt.to_modified = wr_hit && !wt
                    && access_req.line_exclusive;
                if (wr_hit && access_req.line_shared) begin
                    action_nxt.to_exclusive = OLDER_FAMILY
                        ? writeback_select_in
                        : region_promote_ok;
                    action_nxt.read_invalidate = OLDER_FAMILY
                        ? writeback_select_in
                        : region_promote_ok;
                end
            end
            MODE_DISABLED: begin
                action_nxt.allocate    = 1'b0;
                action_nxt.to_modified = wr_hit
                    && access_req.line_exclusive;
                action_nxt.write_memory = access_req.is_write
                    && (!access_req.hit || access_req.line_shared);
            end
        endcase
        action_nxt.l3_allocate = action_nxt.allocate
            && !fsr_value_r[L3_DISABLE_BIT];
        if (!access_req.valid) begin
            action_nxt = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            action_r <= '0;
        end else begin
            action_r <= action_nxt;
        end
    end

    // Older disabled L1 answers snoops only in dual processor systems
    assign l1_accept = (mode != MODE_DISABLED) || dual_processor;

    always_comb begin
        snoop_nxt              = '0;
        snoop_nxt.valid        = snoop_valid;
        snoop_nxt.l1_answer    = snoop_valid && l1_accept;
        snoop_nxt.lower_answer = snoop_valid;
        snoop_nxt.invalidate   = snoop_valid && snoop_inval_req
                                 && (mode != MODE_DISABLED);
    end

    always_ff @(posedge clk) begin
        if (reset) begin
            snoop_reply_r <= '0;
        end else begin
            snoop_reply_r <= snoop_nxt;
        end
    end

    parity_check #(
        .ADDR_W (ADDR_W)
    ) u_parity_check (
        .clk          (clk),
        .reset        (reset),
        .check_en     (l1_accept),
        .snoop_valid  (snoop_valid),
        .snoop_addr   (snoop_addr),
        .snoop_parity (snoop_parity),
        .parity_err_r (parity_err)
    );

    // Parity error retimed to the output flop
    always_ff @(posedge clk) begin
        if (reset) begin
            addr_parity_error_out_r <= 1'b0;
        end else begin
            addr_parity_error_out_r <= parity_err;
        end
    end

    // Explicit invalidation stays allowed in every mode
    always_ff @(posedge clk) begin
        if (reset) begin
            flush_lines_r     <= 1'b0;
            writeback_lines_r <= 1'b0;
        end else begin
            flush_lines_r     <= invalidate_instr
                                 || writeback_invalidate_instr;
            writeback_lines_r <= writeback_invalidate_instr;
        end
    end

    // Page pins follow the selected flags on the older family
    always_ff @(posedge clk) begin
        if (reset) begin
            page_uncached_pin_r      <= 1'b0;
            page_write_through_pin_r <= 1'b0;
        end else begin
            page_uncached_pin_r      <= OLDER_FAMILY && access_req.valid
                                        && sel_uc;
            page_write_through_pin_r <= OLDER_FAMILY && access_req.valid
                                        && sel_wt;
        end
    end

endmodule

// File: hdl/cache_mode_pkg.sv
// Constants, types and the mode decode shared by the cache mode control block.
// Assumes a single core clock with a synchronous active-high reset.
// Functional notes
// - Write-policy set with caching enabled faults, code zero
// - Disable set, write-policy clear selects no-fill mode
// - No-fill read hits served, write hits update lines
// - No-fill write misses bypass; memory written selectively
// - No-fill shared write hit may go exclusive, read-invalidate
// - No-fill keeps invalidation and snoop answers
// - Cache disable alone never forces strict ordering
// - Reset: newer no-fill, older both flags set
// - Older both flags: no fill, exclusive to modified
// - Older both flags: no snoop invalidate, L1 silent unless dual processor
// - Newer: disable set ignores write-policy flag
// - Write-policy at bit 29; both clear write-back
// - Page uncached flag honoured with paging, caching on
// - Page write-through honoured with paging, write-policy clear
// - Page-base flags govern page directory accesses only
// - Feature switch bit 6 disables third-level cache
// - Older disabled L1 snoops only in dual processor
// - Address parity checked only while snoops accepted
// - Older variant applies external enable and select pins
// - Older variant drives page uncached, write-through pins
// - Cache disable at bit 30; clear enables caching
// - Normal mode: cacheable misses fill, write hits update
package cache_mode_pkg;

    localparam int CTRL_W            = 32;
    localparam int FAULT_CODE_W      = 16;
    localparam int WRITE_POLICY_BIT  = 29;
    localparam int CACHE_DISABLE_BIT = 30;
    localparam int L3_DISABLE_BIT    = 6;
    localparam int PAGE_WT_BIT       = 3;
    localparam int PAGE_UC_BIT       = 4;

    localparam logic [FAULT_CODE_W-1:0] FAULT_CODE_ZERO = 16'h0000;
    localparam logic [CTRL_W-1:0]       CTRL_RESET_NEW  = 32'h4000_0000;
    localparam logic [CTRL_W-1:0]       CTRL_RESET_OLD  = 32'h6000_0000;
    localparam logic [CTRL_W-1:0]       PBR_RESET       = 32'h0000_0000;
    localparam logic [CTRL_W-1:0]       FSR_RESET       = 32'h0000_0000;

    typedef enum logic [1:0] {
        MODE_NORMAL,
        MODE_NO_FILL,
        MODE_DISABLED
    } cache_mode_t;

    typedef struct packed {
        logic valid;
        logic is_write;
        logic hit;
        logic line_shared;
        logic line_exclusive;
        logic dir_access;
        logic page_uncached_flag;
        logic page_write_through_flag;
    } access_req_t;

    typedef struct packed {
        logic valid;
        logic cacheable;
        logic write_through;
        logic allocate;
        logic l3_allocate;
        logic update_line;
        logic write_memory;
        logic to_exclusive;
        logic to_modified;
        logic read_invalidate;
    } line_action_t;

    typedef struct packed {
        logic valid;
        logic l1_answer;
        logic lower_answer;
        logic invalidate;
    } snoop_reply_t;

    // Flag pair to operating mode
    function automatic cache_mode_t decode_mode(input logic cd,
                                                input logic nw,
                                                input logic older);
        cache_mode_t m;
        m = MODE_NORMAL;
        if (cd && nw && older) begin
            m = MODE_DISABLED;
        end else if (cd) begin
            m = MODE_NO_FILL;
        end
        return m;
    endfunction

    // Write-policy set while caching enabled
    function automatic logic bad_setting(input logic [CTRL_W-1:0] v);
        return v[WRITE_POLICY_BIT] && !v[CACHE_DISABLE_BIT];
    endfunction

endpackage

// File: hdl/mode_decode.sv
// Combinational decode of the control flags into the cache mode.
// Assumes the control register value is held stable by the caller.
module mode_decode #(
    parameter bit OLDER_FAMILY = 1'b0
) (
    // Control register
    input  wire logic [cache_mode_pkg::CTRL_W-1:0] ctrl_value,
    // Decoded mode
    output cache_mode_pkg::cache_mode_t            mode
);
    import cache_mode_pkg::*;

    logic cd;
    logic nw;

    assign cd = ctrl_value[CACHE_DISABLE_BIT];
    assign nw = ctrl_value[WRITE_POLICY_BIT];

    // Newer family treats both flags set as no-fill
    assign mode = decode_mode(cd, nw, OLDER_FAMILY);

endmodule

// File: hdl/parity_check.sv
// Even parity check on snooped addresses, registered error flag.
// Assumes address and parity are valid in the cycle of snoop_valid.
module parity_check #(
    parameter int ADDR_W = 32
) (
    // Clock and reset
    input  wire logic              clk,
    input  wire logic              reset,
    // Snoop address
    input  wire logic              check_en,
    input  wire logic              snoop_valid,
    input  wire logic [ADDR_W-1:0] snoop_addr,
    input  wire logic              snoop_parity,
    // Result
    output logic                   parity_err_r
);
    logic parity_err_nxt;

    assign parity_err_nxt = check_en && snoop_valid
                            && (^{snoop_addr, snoop_parity});

    always_ff @(posedge clk) begin
        if (reset) begin
            parity_err_r <= 1'b0;
        end else begin
            parity_err_r <= parity_err_nxt;
        end
    end

endmodule

// File: tb/cache_mode_chk.sv
// Port assertions for the cache mode control block.
// Assumes one clock, synchronous active-high reset, bound into the top.
module cache_mode_chk
    import cache_mode_pkg::*;
#(
    parameter bit OLDER_FAMILY = 1'b0,
    parameter int ADDR_W       = 32
) (
    // Clock and reset
    input wire logic              clk,
    input wire logic              reset,
    // Inputs watched
    input wire logic              ctrl_wr_en,
    input wire logic [CTRL_W-1:0] ctrl_wr_data,
    input wire logic              paging_en,
    input wire logic              region_regs_disabled,
    input wire logic              all_uncached,
    input wire logic              dual_processor,
    input access_req_t            access_req,
    input wire logic              snoop_valid,
    input wire logic [ADDR_W-1:0] snoop_addr,
    input wire logic              snoop_parity,
    input wire logic              invalidate_instr,
    // Outputs watched
    input wire logic [CTRL_W-1:0] ctrl_value_r,
    input wire logic [CTRL_W-1:0] fsr_value_r,
    input wire logic              protection_fault_r,
    input wire logic [FAULT_CODE_W-1:0] fault_code_r,
    input cache_mode_t            mode_r,
    input wire logic              strict_order_r,
    input wire logic              l3_enable_r,
    input line_action_t           action_r,
    input snoop_reply_t           snoop_reply_r,
    input wire logic              addr_parity_error_out_r,
    input wire logic              flush_lines_r
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    logic bad_wr, both, dis, en, strict_src, l3_off;
    assign bad_wr = ctrl_wr_en && ctrl_wr_data[29] && !ctrl_wr_data[30];
    assign both = OLDER_FAMILY && ctrl_value_r[30] && ctrl_value_r[29];
    assign dis = both && mode_r == MODE_DISABLED;
    assign en = !both && mode_r != MODE_DISABLED;
    assign strict_src = region_regs_disabled || all_uncached;
    assign l3_off = fsr_value_r[6];
    sequence s_odd_snoop;
        snoop_valid && ^{snoop_addr, snoop_parity};
    endsequence
    property p_fault;
        bad_wr |=> protection_fault_r && fault_code_r == FAULT_CODE_ZERO
            && $stable(ctrl_value_r);
    endproperty
    a_fault: assert property (p_fault) else $error("bad write kept");
    property p_store;
        ctrl_wr_en && !bad_wr |=> ctrl_value_r == $past(ctrl_wr_data);
    endproperty
    a_store: assert property (p_store) else $error("write lost");
    property p_mode;
        !$past(reset) |-> mode_r == (!$past(ctrl_value_r[30]) ? MODE_NORMAL
            : (OLDER_FAMILY && $past(ctrl_value_r[29])) ? MODE_DISABLED
            : MODE_NO_FILL);
    endproperty
    a_mode: assert property (p_mode) else $error("mode wrong");
    property p_alloc;
        access_req.valid && ctrl_value_r[30] |=> action_r.valid
            && !action_r.allocate;
    endproperty
    a_alloc: assert property (p_alloc) else $error("fill");
    property p_update;
        access_req.valid && access_req.is_write && access_req.hit
            |=> action_r.update_line;
    endproperty
    a_update: assert property (p_update) else $error("no update");
    property p_uc;
        access_req.valid && paging_en && !ctrl_value_r[30]
            && !access_req.dir_access && access_req.page_uncached_flag
            |=> !action_r.cacheable;
    endproperty
    a_uc: assert property (p_uc) else $error("uncached page cached");
    property p_strict;
        !$past(reset) |-> strict_order_r == $past(strict_src);
    endproperty
    a_strict: assert property (p_strict) else $error("ordering");
    property p_l3;
        !$past(reset) |-> l3_enable_r != $past(l3_off);
    endproperty
    a_l3: assert property (p_l3) else $error("third level");
    property p_par_on;
        s_odd_snoop ##0 (en || dual_processor) |-> ##2
            addr_parity_error_out_r;
    endproperty
    a_par_on: assert property (p_par_on)
        else $error("parity missed");
    property p_par_off;
        snoop_valid && dis && !dual_processor |-> ##2
            !addr_parity_error_out_r;
    endproperty
    a_par_off: assert property (p_par_off)
        else $error("parity");
    property p_quiet;
        snoop_valid && dis && !dual_processor |=> snoop_reply_r.valid
            && !snoop_reply_r.l1_answer && snoop_reply_r.lower_answer
            && !snoop_reply_r.invalidate;
    endproperty
    a_quiet: assert property (p_quiet)
        else $error("L1 answered");
    property p_answer;
        snoop_valid && en |=> snoop_reply_r.l1_answer
            && snoop_reply_r.lower_answer;
    endproperty
    a_answer: assert property (p_answer) else $error("no answer");
    property p_flush;
        invalidate_instr |=> flush_lines_r;
    endproperty
    a_flush: assert property (p_flush) else $error("no flush");
endmodule

bind cache_mode_control cache_mode_chk #(
    .OLDER_FAMILY(OLDER_FAMILY),
    .ADDR_W      (ADDR_W)
) u_chk (.*);

// File: tb/far_agent.sv
// Model of the snooping bus agent and external cache control hardware.
// Assumes the bench changes its commands at the falling clock edge.
module far_agent #(
    parameter int ADDR_W = 32
) (
    // Clock and bench commands
    input  wire logic              clk,
    input  wire logic              go,
    input  wire logic              bad,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic              area_uc,
    input  wire logic              area_wb,
    // Toward the block
    output logic                   snoop_valid,
    output logic [ADDR_W-1:0]      snoop_addr,
    output logic                   snoop_parity,
    output logic                   cache_enable_in_n,
    output logic                   writeback_select_in
);
    logic [ADDR_W-1:0] idle_r;
    initial idle_r = '0;
    // Idle address lines toggle so no stale value looks valid
    always @(posedge clk) idle_r <= ~snoop_addr;
    assign snoop_valid = go;
    assign snoop_addr = go ? addr : idle_r;
    assign snoop_parity = go ? ^{addr, bad} : idle_r[0];
    // Per-area caching method from the external hardware
    assign cache_enable_in_n = area_uc;
    assign writeback_select_in = area_wb;
endmodule

// File: tb/cache_mode_control_tb.sv
// Self-checking bench for cache mode control, older family build.
// Assumes the far agent model and the bound checker are compiled too.
module cache_mode_control_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import cache_mode_pkg::*;
    logic clk, reset, ctrl_wr_en, pbr_wr_en, fsr_wr_en, paging_en;
    logic [CTRL_W-1:0] ctrl_wr_data, pbr_wr_data, fsr_wr_data, d, exp_q;
    logic region_regs_disabled, all_uncached, region_promote_ok, acc, ca;
    logic dual_processor, invalidate_instr, writeback_invalidate_instr;
    logic snoop_inval_req, go, bad, area_uc, area_wb, snoop_valid;
    logic snoop_parity, cache_enable_in_n, writeback_select_in;
    logic [31:0] addr, snoop_addr;
    access_req_t access_req, ar;
    logic [CTRL_W-1:0] ctrl_value_r, pbr_value_r, fsr_value_r;
    logic protection_fault_r, strict_order_r, l3_enable_r, flush_lines_r;
    logic addr_parity_error_out_r, writeback_lines_r;
    logic page_uncached_pin_r, page_write_through_pin_r;
    logic [FAULT_CODE_W-1:0] fault_code_r;
    cache_mode_t mode_r;
    line_action_t action_r;
    snoop_reply_t snoop_reply_r;
    int bad_count, n_checks, seed, i;

    cache_mode_control #(.OLDER_FAMILY(1'b1), .ADDR_W(32)) uut (.*);
    far_agent #(.ADDR_W(32)) u_far (.*);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    initial begin
        #2000000;
        bad_count++;
        final_report();
    end

    task automatic check(input string what, input logic [31:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            bad_count++;
            $display("unexpected %s: expected %0h seen %0h", what, exp, seen);
        end
    endtask
    task automatic final_report();
        $display("checks %0d mismatches %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    function automatic logic rb();
        logic [31:0] r;
        r = $random(seed);
        return r[0];
    endfunction
    // Mode expected of the older family for a stored control value
    function automatic cache_mode_t exp_mode(input logic [31:0] v);
        return !v[30] ? MODE_NORMAL : v[29] ? MODE_DISABLED : MODE_NO_FILL;
    endfunction

    initial begin
        seed = 33;
        {ctrl_wr_en, pbr_wr_en, fsr_wr_en, paging_en, go, bad} = 6'h00;
        {ctrl_wr_data, pbr_wr_data, fsr_wr_data, addr} = '0;
        {region_regs_disabled, all_uncached, region_promote_ok} = 3'h0;
        {dual_processor, invalidate_instr, writeback_invalidate_instr} = 3'h0;
        {snoop_inval_req, area_uc, area_wb} = 3'h0;
        access_req = '0;
        reset = 1'b1;
        cyc(16);
        reset = 1'b0;
        check("ctrl reset", ctrl_value_r, CTRL_RESET_OLD);
        cyc(2);
        check("reset mode", mode_r, MODE_DISABLED);
        for (i = 0; i < 60; i++) begin
            d = $random(seed);
            if (i < 4) d[30:29] = 2'(i);
            exp_q = (d[29] && !d[30]) ? ctrl_value_r : d;
            {ctrl_wr_en, fsr_wr_en, pbr_wr_en} = 3'h7;
            ctrl_wr_data = d;
            fsr_wr_data = $random(seed);
            pbr_wr_data = $random(seed);
            region_regs_disabled = rb();
            all_uncached = rb();
            cyc(1);
            {ctrl_wr_en, fsr_wr_en, pbr_wr_en} = 3'h0;
            check("fault", protection_fault_r, d[29] && !d[30]);
            check("fault code", fault_code_r, 32'h0);
            check("ctrl", ctrl_value_r, exp_q);
            check("pbr", pbr_value_r, pbr_wr_data);
            check("fsr", fsr_value_r, fsr_wr_data);
            check("strict", strict_order_r,
                  region_regs_disabled | all_uncached);
            d = $random(seed);
            ar = access_req_t'({1'b1, d[6:0]});
            access_req = ar;
            paging_en = rb();
            area_uc = rb();
            area_wb = rb();
            region_promote_ok = rb();
            ca = !((paging_en && (ar.dir_access ? pbr_wr_data[4]
                : ar.page_uncached_flag)) || area_uc);
            cyc(1);
            access_req = '0;
            check("mode", mode_r, exp_mode(exp_q));
            check("l3", l3_enable_r, !fsr_wr_data[6]);
            check("update", action_r.update_line,
                  ar.is_write && ar.hit);
            check("alloc", action_r.allocate,
                  !exp_q[30] && ca && !ar.hit);
            check("uc pin", page_uncached_pin_r, ar.dir_access
                  ? pbr_wr_data[4] : ar.page_uncached_flag);
            check("wt pin", page_write_through_pin_r, ar.dir_access
                  ? pbr_wr_data[3] : ar.page_write_through_flag);
            if (!exp_q[30])
                check("cacheable", action_r.cacheable, ca);
        end
        for (i = 0; i < 6; i++) begin
            ctrl_wr_data = (i % 3 == 0) ? 32'h6000_0000
                : (i % 3 == 1) ? 32'h4000_0000 : 32'h0000_0000;
            dual_processor = (i >= 3);
            ctrl_wr_en = 1'b1;
            cyc(1);
            ctrl_wr_en = 1'b0;
            cyc(2);
            {go, bad, snoop_inval_req} = 3'h7;
            {invalidate_instr, writeback_invalidate_instr} = 2'h3;
            addr = $random(seed);
            cyc(1);
            {go, bad, snoop_inval_req} = 3'h0;
            {invalidate_instr, writeback_invalidate_instr} = 2'h0;
            acc = (i % 3 != 0) || dual_processor;
            check("l1 answer", snoop_reply_r.l1_answer, acc);
            check("lower answer", snoop_reply_r.lower_answer,
                  1'b1);
            check("snoop inval", snoop_reply_r.invalidate,
                  i % 3 != 0);
            check("flush", flush_lines_r, 1'b1);
            check("writeback", writeback_lines_r, 1'b1);
            cyc(1);
            check("parity error", addr_parity_error_out_r, acc);
        end
        final_report();
    end
endmodule
